// *** include/imr_defs.svh ***
// imr_defs.svh: addresses, field positions and reset values of the mask and mute registers
// assumes: included by the package and the register bank
`ifndef IMR_DEFS_SVH
`define IMR_DEFS_SVH

`define IMR_ADDR_W        7
`define IMR_DATA_W        8
`define IMR_FLAG_W        7
`define IMR_ADDR_STATUS   7'h1c
`define IMR_ADDR_MASK     7'h1d
`define IMR_ADDR_MUTE     7'h1e
`define IMR_ADDR_IRQSTAT  7'h60
`define IMR_ADDR_IRQMASK  7'h61
`define IMR_MASK_RES      8'h08
`define IMR_MUTE_VALID    8'h26
`define IMR_MASK_RST      8'h00
`define IMR_MUTE_RST      8'h00
`define IMR_BIT_SILENCE   5
`define IMR_DEEMPH_LO     1
`define IMR_DEEMPH_HI     2
`define IMR_STAT_READ     0
`define IMR_STAT_MUTE     1
`define IMR_STAT_DEEMPH   2

`endif

// *** include/imr_pkg.sv ***
// imr_pkg.sv: types shared by the mask and mute register bank
// assumes: imr_defs.svh on the include path
`include "imr_defs.svh"

package imr_pkg;

	// flags in status-register order: bits 7..4 tx/src, bits 2..0 rx (bit 3 left out)
	typedef struct packed {
		logic rate_conv_fault_flag;
		logic tx_chan_stat_xfer_flag;
		logic tx_user_buf_empty_flag;
		logic tx_chan_stat_sent_flag;
		logic rx_user_buf_new_flag;
		logic rx_chan_stat_block_flag;
		logic rx_fault_flag;
	} imr_flags_t;

	typedef enum logic [3:0] {
		IMR_DEEMPH_NONE = 4'h1,
		IMR_DEEMPH_32K  = 4'h2,
		IMR_DEEMPH_44K1 = 4'h4,
		IMR_DEEMPH_48K  = 4'h8
	} imr_deemph_t;

	typedef struct packed {
		logic [`IMR_DATA_W-1:0] mask;
		logic [`IMR_DATA_W-1:0] mute;
		logic [`IMR_FLAG_W-1:0] flags;
		logic [2:0]             own_stat;
		logic [2:0]             own_mask;
		logic [`IMR_DATA_W-1:0] rdata;
		logic                   irq;
		logic                   silence;
		imr_deemph_t            deemph;
		logic [1:0]             deemph_code;
		logic                   own_irq;
	} imr_state_t;

endpackage : imr_pkg

// *** rtl/imr_regs.sv ***
// imr_regs.sv: interrupt mask register, transmitter tx_silence_and_deemph_select select register,
// the sticky flag bank they gate and a small own interrupt block
// assumes: one clock, synchronous reset, plain register port with read data one cycle later
//
// The plain strobed port was left to the implementer.
`include "imr_defs.svh"

// Functional notes
// - mask bit 6 passes the tx channel-status transfer flag when 1 and blocks it when 0.
// - mask bit 5 passes the tx user-bit buffer empty flag when 1 and blocks it when 0.
// - mask bit 4 passes the tx channel-status block sent flag when 1 and blocks it when 0.
// - mask bit 2 passes the rx user-bit buffer new block flag when 1 and blocks it when 0.
// - mask bit 1 passes the rx channel-status block flag when 1 and blocks it when 0.
// - mask bit 0 passes the rx error flag when 1 and blocks it when 0.
// - bits 2 and 1 of the mute register select the rate-converter input de-emphasis filter.
// - the select codes are 00 none, 01 for 32 kHz, 10 for 44.1 kHz and 11 for 48 kHz.
// - each status flag stays set once set until software reads the status register.
module imr_regs
	import imr_pkg::*;
(
	input  wire logic                   sys_clk_i,
	input  wire logic                   rst_i,
	input  wire logic [`IMR_ADDR_W-1:0] reg_addr_i,
	input  wire logic [`IMR_DATA_W-1:0] reg_wdata_i,
	input  wire logic                   reg_wr_i,
	input  wire logic                   reg_rd_i,
	input  wire imr_flags_t             flag_set_i,
	output logic      [`IMR_DATA_W-1:0] reg_rdata_o,
	output logic                        irq_o,
	output logic                        spdif_tx_silence_o,
	output imr_deemph_t                 rate_conv_deemph_sel_o,
	output logic      [1:0]             rate_conv_deemph_code_o,
	output logic                        own_irq_o
);

	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	imr_state_t st_r;
	imr_state_t st_nxt;

	logic [`IMR_FLAG_W-1:0] set_vec;
	logic [`IMR_FLAG_W-1:0] en_vec;
	logic [`IMR_DATA_W-1:0] stat_view;
	logic [`IMR_DATA_W-1:0] mask_new;
	logic [`IMR_DATA_W-1:0] mute_new;
	logic [2:0]             own_ev;
	logic                   status_rd;

	assign set_vec = flag_set_i;
	// status view places the seven flags around the unused bit 3
	assign stat_view = {st_r.flags[6:3], 1'b0, st_r.flags[2:0]};
	// mask bits line up with the flags, bit 3 excluded
	assign en_vec = {st_r.mask[7:4], st_r.mask[2:0]};
	assign status_rd = reg_rd_i && (reg_addr_i == `IMR_ADDR_STATUS);
	assign mask_new = reg_wdata_i & ~`IMR_MASK_RES;
	assign mute_new = reg_wdata_i & `IMR_MUTE_VALID;

	// --------------------------------------------------------------
	// next state
	// --------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.rdata = '0;

		// register writes
		if (reg_wr_i) begin
			case (reg_addr_i)
				`IMR_ADDR_MASK: begin
					st_nxt.mask = mask_new;
				end
				`IMR_ADDR_MUTE: begin
					st_nxt.mute = mute_new;
				end
				`IMR_ADDR_IRQMASK: begin
					st_nxt.own_mask = reg_wdata_i[2:0];
				end
				default: begin
					st_nxt.mask = st_nxt.mask;
				end
			endcase
		end

		// register reads; unmapped addresses return zero
		if (reg_rd_i) begin
			case (reg_addr_i)
				`IMR_ADDR_STATUS: begin
					st_nxt.rdata = stat_view;
				end
				`IMR_ADDR_MASK: begin
					st_nxt.rdata = st_r.mask;
				end
				`IMR_ADDR_MUTE: begin
					st_nxt.rdata = st_r.mute;
				end
				`IMR_ADDR_IRQSTAT: begin
					st_nxt.rdata = {5'h00, st_r.own_stat};
				end
				`IMR_ADDR_IRQMASK: begin
					st_nxt.rdata = {5'h00, st_r.own_mask};
				end
				default: begin
					st_nxt.rdata = '0;
				end
			endcase
		end

		// sticky flags: a read clears, a new event in the same cycle wins
		if (status_rd) begin
			st_nxt.flags = set_vec;
		end else begin
			st_nxt.flags = st_r.flags | set_vec;
		end

		// interrupt request from enabled flags
		st_nxt.irq = |(st_nxt.flags & en_vec);

		// tx_silence_and_deemph_select outputs
		st_nxt.silence = st_nxt.mute[`IMR_BIT_SILENCE];
		st_nxt.deemph_code = st_nxt.mute[`IMR_DEEMPH_HI:`IMR_DEEMPH_LO];
		case (st_nxt.deemph_code)
			2'h0: begin
				st_nxt.deemph = IMR_DEEMPH_NONE;
			end
			2'h1: begin
				st_nxt.deemph = IMR_DEEMPH_32K;
			end
			2'h2: begin
				st_nxt.deemph = IMR_DEEMPH_44K1;
			end
			default: begin
				st_nxt.deemph = IMR_DEEMPH_48K;
			end
		endcase

		// own events: status read, silence change, de-emphasis change
		own_ev = '0;
		own_ev[`IMR_STAT_READ] = status_rd;
		own_ev[`IMR_STAT_MUTE] = st_nxt.silence != st_r.silence;
		own_ev[`IMR_STAT_DEEMPH] = st_nxt.deemph_code != st_r.deemph_code;
		st_nxt.own_stat = st_r.own_stat | own_ev;
		if (reg_wr_i && (reg_addr_i == `IMR_ADDR_IRQSTAT)) begin
			// write one to clear, set wins
			st_nxt.own_stat = (st_r.own_stat & ~reg_wdata_i[2:0]) | own_ev;
		end
		st_nxt.own_irq = |(st_nxt.own_stat & st_nxt.own_mask);
	end

	// --------------------------------------------------------------
	// registers
	// --------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			st_r             <= '0;
			st_r.mask        <= `IMR_MASK_RST;
			st_r.mute        <= `IMR_MUTE_RST;
			st_r.deemph      <= IMR_DEEMPH_NONE;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata_o             = st_r.rdata;
	assign irq_o                   = st_r.irq;
	assign spdif_tx_silence_o      = st_r.silence;
	assign rate_conv_deemph_sel_o  = st_r.deemph;
	assign rate_conv_deemph_code_o = st_r.deemph_code;
	assign own_irq_o               = st_r.own_irq;

endmodule : imr_regs

// *** verif/imr_regs_properties.sv ***
// imr_regs_properties.sv: checker of the mask and mute bank
// assumes: bound to imr_regs, one clock
`include "imr_defs.svh"
module imr_regs_properties
	import imr_pkg::*;
(
	input wire logic                   sys_clk_i,
	input wire logic                   rst_i,
	input wire logic [`IMR_ADDR_W-1:0] reg_addr_i,
	input wire logic [`IMR_DATA_W-1:0] reg_wdata_i,
	input wire logic                   reg_wr_i,
	input wire logic                   reg_rd_i,
	input wire imr_flags_t             flag_set_i,
	input wire logic [`IMR_DATA_W-1:0] reg_rdata_o,
	input wire logic                   irq_o,
	input wire logic                   spdif_tx_silence_o,
	input wire imr_deemph_t            rate_conv_deemph_sel_o,
	input wire logic [1:0]             rate_conv_deemph_code_o
);
	logic [7:0] msk_r;
	wire        wm = reg_wr_i && reg_addr_i == `IMR_ADDR_MASK;
	wire        we = reg_wr_i && reg_addr_i == `IMR_ADDR_MUTE;
	wire [6:0]  en = {msk_r[7:4], msk_r[2:0]};
	always_ff @(posedge sys_clk_i) msk_r <= rst_i ? 8'h00 : wm ? reg_wdata_i : msk_r;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	sequence s_flag; (flag_set_i & en) != 7'h00 && !wm; endsequence
	a_irq_unmasked: assert property (s_flag |=> irq_o)
		else $error("irq missing");
	a_irq_all_masked: assert property (wm && reg_wdata_i == 8'h00 |-> ##2 !irq_o)
		else $error("irq not masked");
	a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
		else $error("rdata not idle");
	a_mask_resv: assert property (reg_rd_i && reg_addr_i == `IMR_ADDR_MASK |=> !reg_rdata_o[3])
		else $error("mask reserved set");
	a_mute_resv: assert property (reg_rd_i && reg_addr_i == `IMR_ADDR_MUTE
		|=> (reg_rdata_o & ~`IMR_MUTE_VALID) == 8'h00)
		else $error("mute reserved set");
	a_mute_write: assert property (we |=> spdif_tx_silence_o == $past(reg_wdata_i[5]))
		else $error("silence wrong");
	a_silence_hold: assert property (!we |=> $stable(spdif_tx_silence_o))
		else $error("silence moved");
	a_code_write: assert property (we |=> rate_conv_deemph_code_o == $past(reg_wdata_i[2:1]))
		else $error("code wrong");
	a_sel_decode: assert property (rate_conv_deemph_sel_o == 4'h1 << rate_conv_deemph_code_o)
		else $error("sel wrong");
endmodule : imr_regs_properties

bind imr_regs imr_regs_properties i_prop (.sys_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i,
	.reg_wr_i, .reg_rd_i, .flag_set_i, .reg_rdata_o, .irq_o, .spdif_tx_silence_o,
	.rate_conv_deemph_sel_o, .rate_conv_deemph_code_o);

// *** verif/test_imr_regs.sv ***
// test_imr_regs.sv: self-checking bench of the mask and mute bank
// assumes: package and checker compiled first
`include "imr_defs.svh"
module test_imr_regs import imr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic        sys_clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [6:0]  reg_addr_i = '0;
	logic [7:0]  reg_wdata_i = '0;
	logic        reg_wr_i = 1'b0;
	logic        reg_rd_i = 1'b0;
	imr_flags_t  flag_set_i = '0;
	logic [7:0]  reg_rdata_o, m, d, q;
	logic        irq_o, spdif_tx_silence_o, own_irq_o;
	imr_deemph_t rate_conv_deemph_sel_o;
	logic [1:0]  rate_conv_deemph_code_o;
	int          fails = 0;
	int          total_checks = 0;
	always #20 sys_clk_i = ~sys_clk_i;
	imr_regs i_dut (.sys_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
		.flag_set_i, .reg_rdata_o, .irq_o, .spdif_tx_silence_o, .rate_conv_deemph_sel_o,
		.rate_conv_deemph_code_o, .own_irq_o);
	function automatic logic [7:0] view(input int i);
		return i < 3 ? 8'h01 << i : 8'h02 << i;
	endfunction : view
	task automatic chk(input string n, input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		reg_wr_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [6:0] a, output logic [7:0] v);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		#1 v = reg_rdata_o;
	endtask : rd
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (2000) @(posedge sys_clk_i);
		fails++;
		print_verdict();
	end
	initial begin
		void'($urandom(32'h76122f05));
		repeat (10) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		#1 chk("sel rst", rate_conv_deemph_sel_o, 8'h01);
		for (int k = 0; k < 4; k++) begin
			d = ($urandom & 8'hf9) | 8'(k << 1);
			wr(`IMR_ADDR_MUTE, d);
			chk("silence", spdif_tx_silence_o, d[5]);
			chk("code", rate_conv_deemph_code_o, 8'(k));
			chk("sel", rate_conv_deemph_sel_o, 8'h01 << k);
			rd(`IMR_ADDR_MUTE, q);
			chk("mute rd", q, d & `IMR_MUTE_VALID);
		end
		$display("deemph test done");
		for (int i = 0; i < 7; i++) begin
			m = i[0] ? ($urandom | view(i)) : ($urandom & ~view(i));
			wr(`IMR_ADDR_MASK, m);
			@(posedge sys_clk_i);
			flag_set_i <= imr_flags_t'(7'h01 << i);
			@(posedge sys_clk_i);
			flag_set_i <= '0;
			repeat (3) @(posedge sys_clk_i);
			#1 chk("irq", irq_o, i[0]);
			rd(`IMR_ADDR_MASK, q);
			chk("mask rd", q, m & 8'hf7);
			rd(`IMR_ADDR_STATUS, q);
			chk("status", q, view(i));
			rd(`IMR_ADDR_STATUS, q);
			chk("status clr", q, 8'h00);
			chk("irq clr", irq_o, 1'b0);
		end
		wr(`IMR_ADDR_MASK, 8'h00);
		rd(7'h7f, q);
		chk("unmapped", q, 8'h00);
		wr(`IMR_ADDR_MUTE, 8'h00);
		wr(`IMR_ADDR_IRQSTAT, 8'hff);
		wr(`IMR_ADDR_IRQMASK, 8'h07);
		wr(`IMR_ADDR_MUTE, 8'h20);
		@(posedge sys_clk_i);
		#1 chk("own set", own_irq_o, 1'b1);
		wr(`IMR_ADDR_IRQMASK, 8'h00);
		@(posedge sys_clk_i);
		#1 chk("own mask", own_irq_o, 1'b0);
		$display("irq test done");
		print_verdict();
	end
endmodule : test_imr_regs
